/* File: lgcd_pkg.sv */
// Constants and carrier types for the general command decoder
package lgcd_pkg;

	// ----------------------------------------------------------------
	// Command codes (register-select 00)
	// ----------------------------------------------------------------
	localparam logic [1:0] RS_GENERAL = 2'h0;
	localparam logic [7:0] CMD_UPDATE = 8'h00;
	localparam logic [7:0] CMD_INIT = 8'h01;
	localparam logic [7:0] CMD_CALIB = 8'h02;
	localparam logic [7:0] CMD_CLEAR_FLAG = 8'h1f;
	localparam logic [6:0] CMD_CLKOUT_UPPER = 7'h10;
	localparam logic [5:0] CMD_RDSEL_UPPER = 6'h01;

	// ----------------------------------------------------------------
	// Reset values and field positions
	// ----------------------------------------------------------------
	localparam logic CLK_PIN_ENABLE_RST = 1'b0;
	localparam logic CHECKSUM_KIND_RST = 1'b0;
	localparam logic READOUT_SOURCE_RST = 1'b0;
	localparam logic [7:0] CHECKSUM_RST = 8'h00;
	localparam logic [7:0] CRC8_POLY = 8'h07;
	localparam int RDSEL_KIND_BIT = 1;
	localparam int RDSEL_SOURCE_BIT = 0;
	localparam logic [3:0] READ_IDX_CHECKSUM = 4'h0;
	localparam logic [3:0] READ_IDX_LAST = 4'h9;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CLK_FREQ_KHZ = 20000;
	localparam int CALIB_TIME_MS = 10;
	localparam int CALIB_CYCLES = CALIB_TIME_MS * CLK_FREQ_KHZ;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef struct packed {
		logic valid;
		logic rw;
		logic [1:0] register_select;
		logic [7:0] data;
	} lgcd_host_cmd_t;

	typedef struct packed {
		logic [1:0] glyph_memory_select;
		logic step_direction;
		logic display_shift;
		logic line_count;
		logic multiplex_select;
		logic [2:0] inversion_setting;
		logic [4:0] frame_rate_setting;
		logic [5:0][7:0] status_3_to_8;
		logic pump_target_reached;
	} lgcd_settings_t;

	typedef enum logic {
		ST_IDLE = 1'b0,
		ST_CALIB = 1'b1
	} lgcd_state_t;

endpackage

/* File: lgcd_general_command_decoder.sv */
// General control command decoder with status readout and write checksum
`timescale 1ns/1ps

// Summary of operation
// - Update command moves pending settings to active
// - Initialise returns all command registers to defaults
// - Clear command drops the reset-occurred flag
// - Initialise or reload copies calibration cells
// - Calibration reload takes about 10 ms
// - Clock pin driven only when enabled and output
// - Internal clock runs only when something needs it
// - Readout select holds checksum kind and source
// - Checksum over RAM writes, XOR or CRC-8
// - Source 0: status read returns temperature
// - Source 1: checksum then status one to nine
// - Status one: memory, entry, lines, multiplex
// - Status two: inversion and frame rate
// - Reset flag set by any reset, sticky
// - Status nine: pump reached, flag, clock enable
module lgcd_general_command_decoder #(
	parameter int CAL_W = 16,
	parameter int CALIB_CYCLES = lgcd_pkg::CALIB_CYCLES
) (
	input wire logic clk_sys_i,
	input wire logic rst_i,
	input wire lgcd_pkg::lgcd_host_cmd_t host_cmd_i,
	input wire logic rd_start_i,
	output logic [7:0] rd_data_o,
	output logic rd_valid_o,
	input wire logic ram_wr_i,
	input wire logic [7:0] ram_wdata_i,
	input wire logic [7:0] temperature_value_i,
	input wire lgcd_pkg::lgcd_settings_t settings_i,
	input wire logic display_en_i,
	input wire logic pump_en_i,
	input wire logic temp_meas_en_i,
	output logic clk_run_o,
	input wire logic osc_clk_i,
	input wire logic clk_pin_is_output_i,
	output logic clk_pin_o,
	output logic clk_pin_oe_o,
	input wire logic [CAL_W-1:0] otp_cells_i,
	output logic [CAL_W-1:0] calib_o,
	output logic calib_busy_o,
	output logic reg_update_o,
	output logic chip_init_o
);

	localparam int CNT_W = $clog2(CALIB_CYCLES + 1);
	localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(CALIB_CYCLES - 1);

	// ----------------------------------------------------------------
	// Command decode
	// ----------------------------------------------------------------
	logic wr_gen;
	logic rd_gen;
	logic do_update;
	logic do_init;
	logic do_calib;
	logic do_clear;
	logic do_clkout;
	logic do_rdsel;

	assign wr_gen = host_cmd_i.valid && !host_cmd_i.rw
		&& host_cmd_i.register_select == lgcd_pkg::RS_GENERAL;
	assign rd_gen = host_cmd_i.valid && host_cmd_i.rw
		&& host_cmd_i.register_select == lgcd_pkg::RS_GENERAL;
	assign do_update = wr_gen && host_cmd_i.data == lgcd_pkg::CMD_UPDATE;
	assign do_init = wr_gen && host_cmd_i.data == lgcd_pkg::CMD_INIT;
	assign do_calib = wr_gen && host_cmd_i.data == lgcd_pkg::CMD_CALIB;
	assign do_clear = wr_gen && host_cmd_i.data == lgcd_pkg::CMD_CLEAR_FLAG;
	assign do_clkout = wr_gen && host_cmd_i.data[7:1] == lgcd_pkg::CMD_CLKOUT_UPPER;
	assign do_rdsel = wr_gen && host_cmd_i.data[7:2] == lgcd_pkg::CMD_RDSEL_UPPER;

	// ----------------------------------------------------------------
	// Pending and active settings
	// ----------------------------------------------------------------
	// Settings land in a pending copy and only steer the block once the
	// update command arrives, so a half-written set never takes effect.
	logic clk_pin_enable_pend_reg;
	logic checksum_kind_pend_reg;
	logic readout_source_pend_reg;
	logic clk_pin_enable_reg;
	logic checksum_kind_reg;
	logic readout_source_reg;

	always_ff @(posedge clk_sys_i) begin
		if (rst_i || do_init) begin
			clk_pin_enable_pend_reg <= lgcd_pkg::CLK_PIN_ENABLE_RST;
			checksum_kind_pend_reg <= lgcd_pkg::CHECKSUM_KIND_RST;
			readout_source_pend_reg <= lgcd_pkg::READOUT_SOURCE_RST;
		end else begin
			if (do_clkout) begin
				clk_pin_enable_pend_reg <= host_cmd_i.data[0];
			end
			if (do_rdsel) begin
				checksum_kind_pend_reg <= host_cmd_i.data[lgcd_pkg::RDSEL_KIND_BIT];
				readout_source_pend_reg <= host_cmd_i.data[lgcd_pkg::RDSEL_SOURCE_BIT];
			end
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (rst_i || do_init) begin
			clk_pin_enable_reg <= lgcd_pkg::CLK_PIN_ENABLE_RST;
			checksum_kind_reg <= lgcd_pkg::CHECKSUM_KIND_RST;
			readout_source_reg <= lgcd_pkg::READOUT_SOURCE_RST;
		end else if (do_update) begin
			clk_pin_enable_reg <= clk_pin_enable_pend_reg;
			checksum_kind_reg <= checksum_kind_pend_reg;
			readout_source_reg <= readout_source_pend_reg;
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			reg_update_o <= 1'b0;
			chip_init_o <= 1'b0;
		end else begin
			reg_update_o <= do_update;
			chip_init_o <= do_init;
		end
	end

	// ----------------------------------------------------------------
	// Reset-occurred flag
	// ----------------------------------------------------------------
	// Setting beats clearing: an initialise in the same cycle as a clear
	// cannot arrive together, but reset always wins over everything.
	logic reset_occurred_flag_reg;

	always_ff @(posedge clk_sys_i) begin
		if (rst_i || do_init) begin
			reset_occurred_flag_reg <= 1'b1;
		end else if (do_clear) begin
			reset_occurred_flag_reg <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Calibration reload
	// ----------------------------------------------------------------
	lgcd_pkg::lgcd_state_t state_reg;
	logic [CNT_W-1:0] calib_cnt_reg;

	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			state_reg <= lgcd_pkg::ST_IDLE;
			calib_cnt_reg <= '0;
		end else if (do_init || do_calib) begin
			state_reg <= lgcd_pkg::ST_CALIB;
			calib_cnt_reg <= '0;
		end else begin
			case (state_reg)
				lgcd_pkg::ST_IDLE: begin
					calib_cnt_reg <= '0;
				end
				lgcd_pkg::ST_CALIB: begin
					if (calib_cnt_reg == CNT_LAST) begin
						state_reg <= lgcd_pkg::ST_IDLE;
					end
					calib_cnt_reg <= calib_cnt_reg + CNT_W'(1);
				end
				default: begin
					state_reg <= lgcd_pkg::ST_IDLE;
				end
			endcase
		end
	end

	// Cells are taken at the end of the wait, when they have settled.
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			calib_o <= '0;
		end else if (state_reg == lgcd_pkg::ST_CALIB && calib_cnt_reg == CNT_LAST
			&& !(do_init || do_calib)) begin
			calib_o <= otp_cells_i;
		end
	end

	assign calib_busy_o = state_reg == lgcd_pkg::ST_CALIB;

	// ----------------------------------------------------------------
	// Clock gating and clock pin
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			clk_run_o <= 1'b0;
			clk_pin_o <= 1'b0;
			clk_pin_oe_o <= 1'b0;
		end else begin
			clk_run_o <= display_en_i || pump_en_i || temp_meas_en_i;
			clk_pin_o <= osc_clk_i && clk_run_o;
			clk_pin_oe_o <= clk_pin_enable_reg && clk_pin_is_output_i;
		end
	end

	// ----------------------------------------------------------------
	// Write checksum
	// ----------------------------------------------------------------
	function automatic logic [7:0] crc8_step(input logic [7:0] crc, input logic [7:0] d);
		logic [7:0] c;
		c = crc ^ d;
		for (int i = 0; i < 8; i++) begin
			c = c[7] ? ((c << 1) ^ lgcd_pkg::CRC8_POLY) : (c << 1);
		end
		return c;
	endfunction

	logic [7:0] checksum_reg;

	always_ff @(posedge clk_sys_i) begin
		if (rst_i || do_init) begin
			checksum_reg <= lgcd_pkg::CHECKSUM_RST;
		end else if (ram_wr_i) begin
			checksum_reg <= checksum_kind_reg ? crc8_step(checksum_reg, ram_wdata_i)
				: (checksum_reg ^ ram_wdata_i);
		end
	end

	// ----------------------------------------------------------------
	// Status readout
	// ----------------------------------------------------------------
	logic [3:0] read_idx_reg;
	logic [7:0] status_byte;
	logic [3:0] idx_now;

	assign idx_now = rd_start_i ? lgcd_pkg::READ_IDX_CHECKSUM : read_idx_reg;

	always_comb begin
		case (idx_now)
			4'h0: status_byte = checksum_reg;
			4'h1: status_byte = {2'h0, settings_i.glyph_memory_select,
				settings_i.step_direction, settings_i.display_shift,
				settings_i.line_count, settings_i.multiplex_select};
			4'h2: status_byte = {settings_i.inversion_setting,
				settings_i.frame_rate_setting};
			4'h3: status_byte = settings_i.status_3_to_8[0];
			4'h4: status_byte = settings_i.status_3_to_8[1];
			4'h5: status_byte = settings_i.status_3_to_8[2];
			4'h6: status_byte = settings_i.status_3_to_8[3];
			4'h7: status_byte = settings_i.status_3_to_8[4];
			4'h8: status_byte = settings_i.status_3_to_8[5];
			4'h9: status_byte = {5'h00, settings_i.pump_target_reached,
				reset_occurred_flag_reg, clk_pin_enable_reg};
			default: status_byte = 8'h00;
		endcase
	end

	// Past the last status register the walk wraps round to the checksum.
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			read_idx_reg <= lgcd_pkg::READ_IDX_CHECKSUM;
		end else if (rd_gen && readout_source_reg) begin
			read_idx_reg <= (idx_now == lgcd_pkg::READ_IDX_LAST) ? lgcd_pkg::READ_IDX_CHECKSUM
				: idx_now + 4'h1;
		end else if (rd_start_i) begin
			read_idx_reg <= lgcd_pkg::READ_IDX_CHECKSUM;
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			rd_data_o <= 8'h00;
			rd_valid_o <= 1'b0;
		end else begin
			rd_valid_o <= rd_gen;
			if (rd_gen) begin
				rd_data_o <= readout_source_reg ? status_byte : temperature_value_i;
			end
		end
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	sequence s_calib_start;
		do_calib && !do_init;
	endsequence

	sequence s_calib_quiet;
		!(do_init || do_calib) [*8];
	endsequence

	a_update_copies: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		do_update && !do_init |=> readout_source_reg == $past(readout_source_pend_reg)
		&& clk_pin_enable_reg == $past(clk_pin_enable_pend_reg))
		else $error("update did not copy pending settings");

	a_init_defaults: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		do_init |=> !clk_pin_enable_reg && !readout_source_reg && !checksum_kind_reg
		&& checksum_reg == 8'h00 && chip_init_o)
		else $error("initialise left a setting off default");

	a_flag_clear: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		do_clear && !do_init |=> !reset_occurred_flag_reg)
		else $error("reset flag not cleared");

	a_flag_sticky: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		reset_occurred_flag_reg && !do_clear |=> reset_occurred_flag_reg)
		else $error("reset flag fell without a clear");

	a_calib_busy_run: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		s_calib_start ##1 s_calib_quiet |-> calib_busy_o)
		else $error("calibration ended too early");

	a_clkpin_gate: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		clk_pin_oe_o |-> $past(clk_pin_enable_reg) && $past(clk_pin_is_output_i))
		else $error("clock pin driven while disabled");

	a_clock_gate: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		!display_en_i && !pump_en_i && !temp_meas_en_i |=> !clk_run_o)
		else $error("internal clock ran with nothing enabled");

	a_xor_sum: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		ram_wr_i && !checksum_kind_reg && !do_init
		|=> checksum_reg == ($past(checksum_reg) ^ $past(ram_wdata_i)))
		else $error("XOR checksum wrong");

	a_temp_read: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		rd_gen && !readout_source_reg |=> rd_valid_o
		&& rd_data_o == $past(temperature_value_i))
		else $error("temperature readout wrong");

	a_first_checksum: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		rd_gen && rd_start_i && readout_source_reg |=> rd_data_o == $past(checksum_reg))
		else $error("new read did not start at checksum");

	a_status_nine: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		rd_gen && readout_source_reg && idx_now == 4'h9
		|=> rd_data_o[7:3] == 5'h00 && rd_data_o[1] == $past(reset_occurred_flag_reg))
		else $error("status nine layout wrong");

endmodule

/* File: lgcd_host_model.sv */
// Host controller model that sends command bytes and status reads
`timescale 1ns/1ps
module lgcd_host_model (
	input wire logic clk_sys_i,
	output lgcd_pkg::lgcd_host_cmd_t host_cmd_o,
	output logic rd_start_o,
	input wire logic [7:0] rd_data_i,
	input wire logic rd_valid_i
);
	initial begin
		host_cmd_o = '0;
		rd_start_o = 1'b0;
	end

	// One byte per call, taken at the second edge; the bus is released right after it
	task automatic xfer(input logic rw, input logic [7:0] data, input logic start,
		output logic [7:0] rdata, output logic rvalid);
		@(posedge clk_sys_i);
		host_cmd_o <= '{1'b1, rw, lgcd_pkg::RS_GENERAL, data};
		rd_start_o <= start;
		@(posedge clk_sys_i);
		host_cmd_o <= '0;
		rd_start_o <= 1'b0;
		#1;
		rdata = rd_data_i;
		rvalid = rd_valid_i;
	endtask
endmodule

/* File: lgcd_general_command_decoder_tb_top.sv */
// Self-checking testbench for the general command decoder
`timescale 1ns/1ps
module lgcd_general_command_decoder_tb_top;
	localparam int CAL_CYC = 20;
	logic clk_sys_i = 1'b0;
	logic rst_i = 1'b1;
	lgcd_pkg::lgcd_host_cmd_t host_cmd;
	lgcd_pkg::lgcd_settings_t settings_i;
	logic rd_start, rd_valid_o, clk_run_o, clk_pin_o, clk_pin_oe_o;
	logic calib_busy_o, reg_update_o, chip_init_o, rval;
	logic ram_wr_i = 1'b0;
	logic osc_clk_i = 1'b0;
	logic clk_pin_is_output_i = 1'b1;
	logic [2:0] en = 3'h0;
	logic [7:0] ram_wdata_i = 8'h00;
	logic [7:0] temperature_value_i = 8'h5a;
	logic [7:0] rd_data_o, rdat, exp_cs;
	logic [15:0] otp_cells_i = 16'h1234;
	logic [15:0] calib_o;
	int bad_count = 0;
	int cmp_count = 0;

	always #25 clk_sys_i = ~clk_sys_i;
	always @(posedge clk_sys_i) osc_clk_i <= ~osc_clk_i;

	lgcd_host_model host (.clk_sys_i(clk_sys_i), .host_cmd_o(host_cmd),
		.rd_start_o(rd_start), .rd_data_i(rd_data_o), .rd_valid_i(rd_valid_o));

	lgcd_general_command_decoder #(.CAL_W(16), .CALIB_CYCLES(CAL_CYC)) uut (
		.clk_sys_i(clk_sys_i), .rst_i(rst_i), .host_cmd_i(host_cmd),
		.rd_start_i(rd_start), .rd_data_o(rd_data_o), .rd_valid_o(rd_valid_o),
		.ram_wr_i(ram_wr_i), .ram_wdata_i(ram_wdata_i),
		.temperature_value_i(temperature_value_i), .settings_i(settings_i),
		.display_en_i(en[0]), .pump_en_i(en[1]), .temp_meas_en_i(en[2]),
		.clk_run_o(clk_run_o), .osc_clk_i(osc_clk_i),
		.clk_pin_is_output_i(clk_pin_is_output_i), .clk_pin_o(clk_pin_o),
		.clk_pin_oe_o(clk_pin_oe_o), .otp_cells_i(otp_cells_i), .calib_o(calib_o),
		.calib_busy_o(calib_busy_o), .reg_update_o(reg_update_o),
		.chip_init_o(chip_init_o));

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	task automatic stop_test();
		$display("Comparisons %0d, mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
		cmp_count++;
		if (got !== exp) begin
			bad_count++;
			$display("ERROR t=%0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	task automatic wr(input logic [7:0] d);
		host.xfer(1'b0, d, 1'b0, rdat, rval);
	endtask

	task automatic rd(input logic st, input logic [7:0] exp, input string what);
		host.xfer(1'b1, 8'h00, st, rdat, rval);
		check({15'h0, rval}, 16'h1, "read valid");
		check({8'h0, rdat}, {8'h0, exp}, what);
	endtask

	task automatic ram_put(input logic [7:0] d);
		@(posedge clk_sys_i);
		ram_wr_i <= 1'b1;
		ram_wdata_i <= d;
		@(posedge clk_sys_i);
		ram_wr_i <= 1'b0;
	endtask

	// CRC-8, polynomial 07, msb first, no reflection
	function automatic logic [7:0] crc_step(input logic [7:0] c, input logic [7:0] d);
		logic [7:0] r;
		r = c ^ d;
		for (int i = 0; i < 8; i++) r = r[7] ? ({r[6:0], 1'b0} ^ 8'h07) : {r[6:0], 1'b0};
		return r;
	endfunction

	task automatic sweep(input logic [7:0] cs, input logic [1:0] f9);
		rd(1'b1, cs, "checksum");
		rd(1'b0, 8'h2a, "status 1");
		rd(1'b0, 8'hb3, "status 2");
		for (int i = 0; i < 6; i++) begin
			rd(1'b0, settings_i.status_3_to_8[i], "status 3-8");
		end
		rd(1'b0, {5'h00, 1'b1, f9}, "status 9");
	endtask

	task automatic calib_wait(input logic [15:0] exp);
		check({15'h0, calib_busy_o}, 16'h1, "reload busy");
		repeat (CAL_CYC - 3) @(posedge clk_sys_i);
		#1;
		check({15'h0, calib_busy_o}, 16'h1, "reload still busy");
		repeat (4) @(posedge clk_sys_i);
		#1;
		check({15'h0, calib_busy_o}, 16'h0, "reload done");
		check(calib_o, exp, "calibration copy");
	endtask

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		settings_i = '0;
		settings_i.glyph_memory_select = 2'h2;
		settings_i.step_direction = 1'b1;
		settings_i.line_count = 1'b1;
		settings_i.inversion_setting = 3'h5;
		settings_i.frame_rate_setting = 5'h13;
		settings_i.status_3_to_8 = 48'h887766554433;
		settings_i.pump_target_reached = 1'b1;
		repeat (6) @(posedge clk_sys_i);
		rst_i <= 1'b0;
		#1;
		check({15'h0, clk_pin_oe_o}, 16'h0, "pin released in reset");
		check(calib_o, 16'h0, "calibration in reset");
		wr(lgcd_pkg::CMD_INIT);
		check({15'h0, chip_init_o}, 16'h1, "init pulse");
		calib_wait(16'h1234);
		rd(1'b1, 8'h5a, "temperature");
		@(posedge clk_sys_i);
		temperature_value_i <= 8'hc3;
		wr(8'h05);
		rd(1'b1, 8'hc3, "pending source");
		wr(lgcd_pkg::CMD_UPDATE);
		check({15'h0, reg_update_o}, 16'h1, "update pulse");
		sweep(8'h00, 2'b10);
		rd(1'b0, 8'h00, "wrap to checksum");
		rd(1'b0, 8'h2a, "status 1 again");
		rd(1'b1, 8'h00, "restart");
		wr(lgcd_pkg::CMD_CLEAR_FLAG);
		wr(8'h21);
		wr(lgcd_pkg::CMD_UPDATE);
		sweep(8'h00, 2'b01);
		exp_cs = 8'h00;
		for (int i = 0; i < 16; i++) begin
			ram_put(8'h11 * i[7:0] + 8'h3c);
			exp_cs = exp_cs ^ (8'h11 * i[7:0] + 8'h3c);
		end
		rd(1'b1, exp_cs, "xor checksum");
		check({15'h0, clk_pin_oe_o}, 16'h1, "pin driven");
		for (int i = 0; i < 3; i++) begin
			@(posedge clk_sys_i);
			en <= 3'h1 << i;
			repeat (3) @(posedge clk_sys_i);
			#1;
			check({14'h0, clk_run_o, clk_pin_o}, {14'h0, 1'b1, ~osc_clk_i}, "clock on");
			@(posedge clk_sys_i);
			en <= 3'h0;
			repeat (3) @(posedge clk_sys_i);
			#1;
			check({14'h0, clk_run_o, clk_pin_o}, 16'h0, "clock gated");
		end
		@(posedge clk_sys_i);
		clk_pin_is_output_i <= 1'b0;
		repeat (3) @(posedge clk_sys_i);
		#1;
		check({15'h0, clk_pin_oe_o}, 16'h0, "pin input");
		wr(8'h20);
		wr(lgcd_pkg::CMD_UPDATE);
		@(posedge clk_sys_i);
		clk_pin_is_output_i <= 1'b1;
		repeat (3) @(posedge clk_sys_i);
		#1;
		check({15'h0, clk_pin_oe_o}, 16'h0, "pin disabled by command");
		wr(lgcd_pkg::CMD_INIT);
		wr(8'h07);
		wr(lgcd_pkg::CMD_UPDATE);
		exp_cs = 8'h00;
		for (int i = 0; i < 4; i++) begin
			ram_put(8'ha5 ^ i[7:0]);
			exp_cs = crc_step(exp_cs, 8'ha5 ^ i[7:0]);
		end
		sweep(exp_cs, 2'b10);
		repeat (CAL_CYC) @(posedge clk_sys_i);
		otp_cells_i <= 16'hbeef;
		wr(lgcd_pkg::CMD_CALIB);
		check(calib_o, 16'h1234, "old calibration kept");
		calib_wait(16'hbeef);
		stop_test();
	end

	initial begin
		repeat (5000) @(posedge clk_sys_i);
		bad_count++;
		$display("ERROR t=%0t watchdog expired", $time);
		stop_test();
	end
endmodule
